/* rtl/tcr_pkg.sv */
// constants and types of the 16-bit timer channel control block
package tcr_pkg;

  localparam int unsigned TCR_AW = 16;
  localparam int unsigned TCR_DW = 32;

  // register indices; byte address is four times the index
  localparam logic [13:0] TCR_IDX_CMPA_LO = 14'h002d;
  localparam logic [13:0] TCR_IDX_CMPA_HI = 14'h002e;
  localparam logic [13:0] TCR_IDX_MODE = 14'h0031;
  localparam logic [13:0] TCR_IDX_CTRL = 14'h0032;
  localparam logic [13:0] TCR_IDX_STAT = 14'h0033;
  localparam logic [13:0] TCR_IDX_GATE = 14'h0f74;

  // reset values
  localparam logic [7:0] TCR_RST_GATE = 8'h00;
  localparam logic [7:0] TCR_RST_MODE = 8'h80;
  localparam logic [7:0] TCR_RST_CTRL = 8'h00;
  localparam logic [15:0] TCR_RST_CMPA = 16'hffff;

  // gate register fields
  localparam int unsigned TCR_GATE_CH0 = 0;
  localparam int unsigned TCR_GATE_CH1 = 1;
  localparam int unsigned TCR_GATE_PAIR_A = 4;
  localparam int unsigned TCR_GATE_PAIR_B = 5;

  // mode register fields
  localparam int unsigned TCR_MODE_DBUF = 7;
  localparam int unsigned TCR_MODE_TPOL = 6;
  localparam int unsigned TCR_MODE_SHARED = 5;
  localparam int unsigned TCR_MODE_CK_LSB = 3;
  localparam int unsigned TCR_MODE_OP_LSB = 0;

  // control register fields
  localparam int unsigned TCR_CTRL_OVE = 7;
  localparam int unsigned TCR_CTRL_TFF = 6;
  localparam int unsigned TCR_CTRL_NC_LSB = 4;
  localparam int unsigned TCR_CTRL_ACAP = 3;
  localparam int unsigned TCR_CTRL_PPG = 2;
  localparam int unsigned TCR_CTRL_RUN = 0;
  localparam logic [7:0] TCR_CTRL_RD_MASK = 8'hf1;

  // status register fields
  localparam int unsigned TCR_STAT_OVF = 7;
  localparam int unsigned TCR_STAT_CPA = 1;
  localparam int unsigned TCR_STAT_CPB = 0;

  // divider exponents of the source clock
  localparam logic [3:0] TCR_CK_EXP_00 = 4'ha;
  localparam logic [3:0] TCR_CK_EXP_01 = 4'h6;
  localparam logic [3:0] TCR_CK_EXP_10 = 4'h2;
  localparam logic [3:0] TCR_CK_EXP_11 = 4'h1;
  localparam logic [3:0] TCR_CK_EXP_LF = 4'h3;

  // divider exponents of the noise canceller sampling
  localparam logic [3:0] TCR_NC_EXP_01 = 4'h1;
  localparam logic [3:0] TCR_NC_EXP_10 = 4'h2;
  localparam logic [3:0] TCR_NC_EXP_11 = 4'h8;
  localparam logic [3:0] TCR_NC_EXP_LF = 4'h1;

  typedef enum logic [2:0] {
    TCR_OP_TIMER,
    TCR_OP_EVENT,
    TCR_OP_PULSE_SW,
    TCR_OP_EXT_TRIG,
    TCR_OP_WINDOW,
    TCR_OP_PULSE_WIDTH,
    TCR_OP_RESERVED
  } tcr_op_mode_t;

endpackage

/* rtl/tcr_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module tcr_sync
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end
    else if (ce)
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
      begin
        dout <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/tcr_top.sv */
// control registers of one 16-bit timer channel behind an APB slave
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module tcr_top
  import tcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [TCR_AW-1:0] paddr,
  input wire logic [TCR_DW-1:0] pwdata,
  output logic [TCR_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_clk_divsel,
  input wire logic low_speed,
  input wire logic stop_entry,
  input wire logic ovf_event,
  input wire logic cap_a_event,
  input wire logic cap_b_event,
  input wire logic match_event,
  input wire logic trig_pin,
  output logic clock_gate_ch0,
  output logic clock_gate_ch1,
  output logic clock_gate_8bit_pair_a,
  output logic clock_gate_8bit_pair_b,
  output logic run_control,
  output logic flipflop_init,
  output logic pulse_oneshot_select,
  output tcr_op_mode_t op_mode,
  output logic src_use_low_freq,
  output logic [3:0] src_div_exp,
  output logic [3:0] nf_div_exp,
  output logic nf_use_low_freq,
  output logic nf_halted,
  output logic cap_single_edge,
  output logic trig_stop_select,
  output logic capture_active,
  output logic trig_active,
  output logic timer_irq,
  output logic [15:0] compare_reg_a
);
  logic [7:0] gate_reg;
  logic [7:0] mode_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic ovf_flag_reg;
  logic capture_flag_a_reg;
  logic capture_flag_b_reg;
  logic [7:0] cmp_tmp_reg;
  logic [15:0] cmp_set_reg;
  logic cmp_pend_reg;
  logic [7:0] rd_byte;
  logic trig_sync;

  // bus decode
  wire logic setup = psel && !penable && !pready;
  wire logic access = psel && penable && pready;
  wire logic [13:0] idx = paddr[TCR_AW-1:2];
  wire logic aligned = paddr[1:0] == 2'b00;
  wire logic hit_lo = aligned && idx == TCR_IDX_CMPA_LO;
  wire logic hit_hi = aligned && idx == TCR_IDX_CMPA_HI;
  wire logic hit_mode = aligned && idx == TCR_IDX_MODE;
  wire logic hit_ctrl = aligned && idx == TCR_IDX_CTRL;
  wire logic hit_stat = aligned && idx == TCR_IDX_STAT;
  wire logic hit_gate = aligned && idx == TCR_IDX_GATE;
  wire logic hit_any = hit_lo || hit_hi || hit_mode || hit_ctrl || hit_stat
    || hit_gate;
  wire logic wr = access && pwrite;
  wire logic wr_gate = wr && hit_gate;
  wire logic wr_mode = wr && hit_mode;
  wire logic wr_ctrl = wr && hit_ctrl;
  wire logic wr_lo = wr && hit_lo;
  wire logic wr_hi = wr && hit_hi;
  wire logic rd_clr = access && !pwrite && hit_stat;
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic running = ctrl_reg[TCR_CTRL_RUN];

  // field views
  wire logic [2:0] op_code = mode_reg[TCR_MODE_OP_LSB +: 3];
  wire logic [1:0] ck_code = mode_reg[TCR_MODE_CK_LSB +: 2];
  wire logic [1:0] nc_code = ctrl_reg[TCR_CTRL_NC_LSB +: 2];
  wire logic shared_bit = mode_reg[TCR_MODE_SHARED];
  wire logic dbuf_enable = mode_reg[TCR_MODE_DBUF];
  wire logic ext_trig_polarity = mode_reg[TCR_MODE_TPOL];
  wire logic auto_capture_enable = ctrl_reg[TCR_CTRL_ACAP];
  wire logic ovf_irq_enable = ctrl_reg[TCR_CTRL_OVE];
  wire logic [7:0] stat_byte = {ovf_flag_reg, 5'b0_0000, capture_flag_a_reg,
    capture_flag_b_reg};

  // operation mode decode
  tcr_op_mode_t op_dec;
  always_comb
  begin
    case (op_code)
      3'b000: op_dec = TCR_OP_TIMER;
      3'b001: op_dec = TCR_OP_TIMER;
      3'b010: op_dec = TCR_OP_EVENT;
      3'b011: op_dec = TCR_OP_PULSE_SW;
      3'b100: op_dec = TCR_OP_EXT_TRIG;
      3'b101: op_dec = TCR_OP_WINDOW;
      3'b110: op_dec = TCR_OP_PULSE_WIDTH;
      default: op_dec = TCR_OP_RESERVED;
    endcase
  end

  // source clock selection
  wire logic ck_lf = ck_code == 2'b00 && (slow_clk_divsel || low_speed);
  logic [3:0] ck_exp;
  always_comb
  begin
    case (ck_code)
      2'b00: ck_exp = ck_lf ? TCR_CK_EXP_LF : TCR_CK_EXP_00;
      2'b01: ck_exp = TCR_CK_EXP_01;
      2'b10: ck_exp = TCR_CK_EXP_10;
      default: ck_exp = TCR_CK_EXP_11;
    endcase
  end

  // noise canceller sampling; exponent 0 means no filtering
  wire logic nc_lf = low_speed && nc_code == 2'b11;
  wire logic nc_halt = low_speed && (nc_code == 2'b01 || nc_code == 2'b10);
  logic [3:0] nc_exp;
  always_comb
  begin
    case (nc_code)
      2'b00: nc_exp = 4'h0;
      2'b01: nc_exp = TCR_NC_EXP_01;
      2'b10: nc_exp = TCR_NC_EXP_10;
      default: nc_exp = nc_lf ? TCR_NC_EXP_LF : TCR_NC_EXP_11;
    endcase
  end

  wire logic cap_mode = op_dec == TCR_OP_TIMER || op_dec == TCR_OP_EVENT
    || op_dec == TCR_OP_EXT_TRIG || op_dec == TCR_OP_WINDOW;

  // control write: locked fields keep value while running
  wire logic [7:0] lock_mask = 8'hf0 & ~(8'h01 << TCR_CTRL_RUN)
    & ~(8'h01 << TCR_CTRL_ACAP) & ~(8'h01 << TCR_CTRL_PPG);
  wire logic acap_hold = running && !wbyte[TCR_CTRL_RUN];
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
    begin
      if (running)
      begin
        ctrl_next = (ctrl_reg & lock_mask) | (wbyte & ~lock_mask);
      end
      else
      begin
        ctrl_next = wbyte;
      end
      if (acap_hold)
      begin
        ctrl_next[TCR_CTRL_ACAP] = ctrl_reg[TCR_CTRL_ACAP];
      end
      ctrl_next[1] = 1'b0;
    end
    if (stop_entry)
    begin
      ctrl_next[TCR_CTRL_RUN] = 1'b0;
    end
  end

  // read data selection
  always_comb
  begin
    if (hit_lo)
    begin
      rd_byte = cmp_set_reg[7:0];
    end
    else if (hit_hi)
    begin
      rd_byte = cmp_set_reg[15:8];
    end
    else if (hit_mode)
    begin
      rd_byte = mode_reg;
    end
    else if (hit_ctrl)
    begin
      rd_byte = ctrl_reg & TCR_CTRL_RD_MASK;
    end
    else if (hit_stat)
    begin
      rd_byte = stat_byte;
    end
    else if (hit_gate)
    begin
      rd_byte = gate_reg;
    end
    else
    begin
      rd_byte = 8'h00;
    end
  end

  // apb answer: data sampled in setup, ready in the single access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= setup;
      pslverr <= setup && !hit_any;
      if (setup && !pwrite)
      begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_reg <= TCR_RST_GATE;
      mode_reg <= TCR_RST_MODE;
      ctrl_reg <= TCR_RST_CTRL;
    end
    else if (ce)
    begin
      if (wr_gate)
      begin
        gate_reg <= wbyte;
      end
      if (wr_mode && !running)
      begin
        mode_reg <= wbyte;
      end
      ctrl_reg <= ctrl_next;
    end
  end

  // status flags: only bits shown by this read are cleared, set wins
  wire logic [7:0] clr = rd_clr ? prdata[7:0] : 8'h00;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_flag_reg <= 1'b0;
      capture_flag_a_reg <= 1'b0;
      capture_flag_b_reg <= 1'b0;
    end
    else if (ce)
    begin
      ovf_flag_reg <= (ovf_flag_reg && !clr[TCR_STAT_OVF]) || ovf_event;
      capture_flag_a_reg <= (capture_flag_a_reg && !clr[TCR_STAT_CPA])
        || cap_a_event;
      capture_flag_b_reg <= (capture_flag_b_reg && !clr[TCR_STAT_CPB])
        || cap_b_event;
    end
  end

  // compare register A with temporary low byte and double buffer
  wire logic cmp_wr_ok = op_dec != TCR_OP_PULSE_WIDTH;
  wire logic cmp_defer = dbuf_enable && running;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_tmp_reg <= TCR_RST_CMPA[7:0];
      cmp_set_reg <= TCR_RST_CMPA;
      compare_reg_a <= TCR_RST_CMPA;
      cmp_pend_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_lo && cmp_wr_ok)
      begin
        cmp_tmp_reg <= wbyte;
      end
      if (wr_hi && cmp_wr_ok)
      begin
        cmp_set_reg <= {wbyte, cmp_tmp_reg};
        cmp_pend_reg <= cmp_defer;
        if (!cmp_defer)
        begin
          compare_reg_a <= {wbyte, cmp_tmp_reg};
        end
      end
      else if (cmp_pend_reg && (match_event || !running))
      begin
        compare_reg_a <= cmp_set_reg;
        cmp_pend_reg <= 1'b0;
      end
    end
  end

  tcr_sync u_trig_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(trig_pin),
    .dout(trig_sync)
  );

  // decoded controls towards the counting logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_mode <= TCR_OP_TIMER;
      src_use_low_freq <= 1'b0;
      src_div_exp <= TCR_CK_EXP_00;
      nf_div_exp <= 4'h0;
      nf_use_low_freq <= 1'b0;
      nf_halted <= 1'b0;
      cap_single_edge <= 1'b0;
      trig_stop_select <= 1'b0;
      capture_active <= 1'b0;
      trig_active <= 1'b0;
      timer_irq <= 1'b0;
    end
    else if (ce)
    begin
      op_mode <= op_dec;
      src_use_low_freq <= ck_lf;
      src_div_exp <= ck_exp;
      nf_div_exp <= nc_halt ? 4'h0 : nc_exp;
      nf_use_low_freq <= nc_lf;
      nf_halted <= nc_halt;
      cap_single_edge <= op_dec == TCR_OP_PULSE_WIDTH && shared_bit;
      trig_stop_select <= op_dec == TCR_OP_EXT_TRIG && shared_bit;
      capture_active <= auto_capture_enable && cap_mode;
      trig_active <= trig_sync ^ ext_trig_polarity;
      timer_irq <= ovf_event && ovf_irq_enable;
    end
  end

  // plain register views
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_gate_ch0 <= 1'b0;
      clock_gate_ch1 <= 1'b0;
      clock_gate_8bit_pair_a <= 1'b0;
      clock_gate_8bit_pair_b <= 1'b0;
      run_control <= 1'b0;
      flipflop_init <= 1'b0;
      pulse_oneshot_select <= 1'b0;
    end
    else if (ce)
    begin
      clock_gate_ch0 <= gate_reg[TCR_GATE_CH0];
      clock_gate_ch1 <= gate_reg[TCR_GATE_CH1];
      clock_gate_8bit_pair_a <= gate_reg[TCR_GATE_PAIR_A];
      clock_gate_8bit_pair_b <= gate_reg[TCR_GATE_PAIR_B];
      run_control <= ctrl_next[TCR_CTRL_RUN];
      flipflop_init <= ctrl_reg[TCR_CTRL_TFF];
      pulse_oneshot_select <= ctrl_reg[TCR_CTRL_PPG];
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_mode_write_lock: assert property (ce && wr_mode && running |=>
    mode_reg == $past(mode_reg))
    else $error("mode register changed while running");

  a_ctrl_lock_fields: assert property (ce && wr_ctrl && running |=>
    ctrl_reg[7:4] == $past(ctrl_reg[7:4]))
    else $error("locked control fields changed while running");

  a_run_stop_clear: assert property (ce && wr_ctrl && !wbyte[0] |=>
    !run_control && !running)
    else $error("run bit not cleared by write of zero");

  a_stop_mode_halt: assert property (ce && stop_entry |=> !running)
    else $error("stop entry left the timer running");

  a_ctrl_read_zero: assert property (access && hit_ctrl && !pwrite |->
    prdata[3:2] == 2'b00)
    else $error("control bits 3 and 2 read nonzero");

  a_stat_read_zero: assert property (access && hit_stat && !pwrite |->
    prdata[6:2] == 5'b0_0000 && prdata[31:8] == 24'h00_0000)
    else $error("status reserved bits read nonzero");

  a_flag_set_wins: assert property (ce && rd_clr && ovf_event |=>
    ovf_flag_reg)
    else $error("overflow flag lost");

  a_ovf_flag_set: assert property (ce && ovf_event |=> ovf_flag_reg)
    else $error("overflow flag not set");

  a_stat_read_clear: assert property (ce && rd_clr && prdata[0]
    && !cap_b_event |=> !capture_flag_b_reg)
    else $error("capture flag B not cleared by read");

  a_irq_gated: assert property (ce && ovf_event |=>
    timer_irq == $past(ovf_irq_enable))
    else $error("overflow request not gated by enable");

  a_cmp_pair_load: assert property (ce && wr_hi && cmp_wr_ok && !cmp_defer |=>
    compare_reg_a == {$past(wbyte), $past(cmp_tmp_reg)})
    else $error("compare A not loaded from both bytes");

  a_filter_halt: assert property (ce && low_speed && nc_code == 2'b01
    |=> nf_halted && nf_div_exp == 4'h0)
    else $error("slow mode filter code did not halt");

  a_gate_after_reset: assert property ($rose(presetn) |->
    !clock_gate_ch0 && !clock_gate_ch1)
    else $error("gate bits not cleared by reset");

  c_status_clear: cover property (rd_clr && prdata[7]);
  c_dbuf_reload: cover property (cmp_pend_reg && match_event && ce);
  c_stop_entry: cover property (running && stop_entry && ce);
  c_unmapped: cover property (access && pslverr);
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking testbench of the timer channel control registers
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tcr_pkg::*;
  typedef struct {logic wr; logic [13:0] idx; logic [7:0] wd; logic [7:0] ex;} tcr_row_t;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, slow_clk_divsel = 1'b0, low_speed = 1'b0, stop_entry = 1'b0;
  logic ovf_event = 1'b0, cap_a_event = 1'b0, cap_b_event = 1'b0, match_event = 1'b0;
  logic trig_pin = 1'b0, ev_in_read = 1'b0;
  logic clock_gate_ch0, clock_gate_ch1, clock_gate_8bit_pair_a, clock_gate_8bit_pair_b;
  logic run_control, flipflop_init, pulse_oneshot_select, src_use_low_freq, nf_use_low_freq;
  logic nf_halted, cap_single_edge, trig_stop_select, capture_active, trig_active, timer_irq;
  logic [3:0] src_div_exp, nf_div_exp;
  logic [15:0] compare_reg_a;
  tcr_op_mode_t op_mode;
  logic [7:0] rd;
  logic err;
  int fail_count = 0, num_checks = 0;
  tcr_row_t rows[14];
  tcr_op_mode_t op_exp[8];
  logic [3:0] ck_exp[4], nc_exp[4];

  tcr_top i_tcr_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clk_divsel(slow_clk_divsel), .low_speed(low_speed),
    .stop_entry(stop_entry), .ovf_event(ovf_event), .cap_a_event(cap_a_event),
    .cap_b_event(cap_b_event), .match_event(match_event), .trig_pin(trig_pin),
    .clock_gate_ch0(clock_gate_ch0), .clock_gate_ch1(clock_gate_ch1),
    .clock_gate_8bit_pair_a(clock_gate_8bit_pair_a),
    .clock_gate_8bit_pair_b(clock_gate_8bit_pair_b), .run_control(run_control),
    .flipflop_init(flipflop_init), .pulse_oneshot_select(pulse_oneshot_select),
    .op_mode(op_mode), .src_use_low_freq(src_use_low_freq), .src_div_exp(src_div_exp),
    .nf_div_exp(nf_div_exp), .nf_use_low_freq(nf_use_low_freq), .nf_halted(nf_halted),
    .cap_single_edge(cap_single_edge), .trig_stop_select(trig_stop_select),
    .capture_active(capture_active), .trig_active(trig_active), .timer_irq(timer_irq),
    .compare_reg_a(compare_reg_a));

  always #12.5 pclk = ~pclk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    ovf_event <= ev_in_read;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ovf_event <= 1'b0;
    if (n >= 20)
      check(32'h0000_0000, 32'h0000_0001);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #(25 * 6000);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    rows = '{'{0, TCR_IDX_GATE, 8'h00, 8'h00}, '{0, TCR_IDX_MODE, 8'h00, 8'h80},
      '{0, TCR_IDX_CTRL, 8'h00, 8'h00}, '{0, TCR_IDX_STAT, 8'h00, 8'h00},
      '{0, TCR_IDX_CMPA_HI, 8'h00, 8'hff}, '{0, TCR_IDX_CMPA_LO, 8'h00, 8'hff},
      '{1, TCR_IDX_GATE, 8'h33, 8'h00}, '{0, TCR_IDX_GATE, 8'h00, 8'h33},
      '{1, TCR_IDX_CTRL, 8'hfc, 8'h00}, '{0, TCR_IDX_CTRL, 8'h00, 8'hf0},
      '{1, TCR_IDX_STAT, 8'hff, 8'h00}, '{0, TCR_IDX_STAT, 8'h00, 8'h00},
      '{1, TCR_IDX_MODE, 8'h4e, 8'h00}, '{0, TCR_IDX_MODE, 8'h00, 8'h4e}};
    op_exp = '{TCR_OP_TIMER, TCR_OP_TIMER, TCR_OP_EVENT, TCR_OP_PULSE_SW, TCR_OP_EXT_TRIG,
      TCR_OP_WINDOW, TCR_OP_PULSE_WIDTH, TCR_OP_RESERVED};
    ck_exp = '{4'ha, 4'h6, 4'h2, 4'h1};
    nc_exp = '{4'h0, 4'h1, 4'h2, 4'h8};
    cyc(8);
    presetn <= 1'b1;
    cyc(2);
    foreach (rows[k])
    begin
      apb(rows[k].wr, rows[k].idx, rows[k].wd);
      if (!rows[k].wr)
        check({24'h0, rd}, {24'h0, rows[k].ex});
    end
    cyc(2);
    check({28'h0, clock_gate_8bit_pair_b, clock_gate_8bit_pair_a, clock_gate_ch1,
      clock_gate_ch0}, 32'h0000_000f);
    $display("register table test done");
    apb(1, TCR_IDX_CTRL, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      apb(1, TCR_IDX_MODE, {3'b100, i[1:0], i[2:0]});
      cyc(2);
      check({29'h0, op_mode}, {29'h0, op_exp[i]});
      check({28'h0, src_div_exp}, {28'h0, ck_exp[i[1:0]]});
    end
    slow_clk_divsel <= 1'b1;
    apb(1, TCR_IDX_MODE, 8'h80);
    cyc(2);
    check({27'h0, src_use_low_freq, src_div_exp}, 32'h0000_0013);
    slow_clk_divsel <= 1'b0;
    for (int j = 0; j < 4; j++)
    begin
      apb(1, TCR_IDX_CTRL, {2'b00, j[1:0], 4'h0});
      cyc(2);
      check({28'h0, nf_div_exp}, {28'h0, nc_exp[j]});
    end
    low_speed <= 1'b1;
    cyc(2);
    check({27'h0, nf_use_low_freq, nf_div_exp}, 32'h0000_0011);
    apb(1, TCR_IDX_CTRL, 8'h10);
    cyc(2);
    check({31'h0, nf_halted}, 32'h0000_0001);
    low_speed <= 1'b0;
    apb(1, TCR_IDX_MODE, 8'ha6);
    cyc(2);
    check({31'h0, cap_single_edge}, 32'h0000_0001);
    apb(1, TCR_IDX_MODE, 8'ha4);
    trig_pin <= 1'b1;
    cyc(2);
    check({31'h0, trig_stop_select}, 32'h0000_0001);
    cyc(4);
    check({31'h0, trig_active}, 32'h0000_0001);
    apb(1, TCR_IDX_MODE, 8'he4);
    cyc(2);
    check({31'h0, trig_active}, 32'h0000_0000);
    apb(1, TCR_IDX_CTRL, 8'h4c);
    cyc(2);
    check({29'h0, flipflop_init, capture_active, pulse_oneshot_select}, 32'h0000_0007);
    apb(1, TCR_IDX_MODE, 8'ha6);
    cyc(2);
    check({31'h0, capture_active}, 32'h0000_0000);
    $display("decode test done");
    // start running, then try to change mode and control fields
    apb(1, TCR_IDX_MODE, 8'h80);
    apb(1, TCR_IDX_CTRL, 8'h81);
    cyc(1);
    check({31'h0, run_control}, 32'h0000_0001);
    apb(1, TCR_IDX_MODE, 8'h07);
    apb(0, TCR_IDX_MODE, 8'h00);
    check({24'h0, rd}, 32'h0000_0080);
    apb(1, TCR_IDX_CTRL, 8'h71);
    apb(0, TCR_IDX_CTRL, 8'h00);
    check({24'h0, rd}, 32'h0000_0081);
    @(posedge pclk);
    ovf_event <= 1'b1;
    @(posedge pclk);
    ovf_event <= 1'b0;
    @(posedge pclk);
    check({31'h0, timer_irq}, 32'h0000_0001);
    cap_a_event <= 1'b1;
    cap_b_event <= 1'b1;
    @(posedge pclk);
    cap_a_event <= 1'b0;
    cap_b_event <= 1'b0;
    ev_in_read <= 1'b1;
    apb(0, TCR_IDX_STAT, 8'h00);
    check({24'h0, rd}, 32'h0000_0083);
    ev_in_read <= 1'b0;
    apb(0, TCR_IDX_STAT, 8'h00);
    check({24'h0, rd}, 32'h0000_0080);
    apb(0, TCR_IDX_STAT, 8'h00);
    check({24'h0, rd}, 32'h0000_0000);
    // double buffer pends the new compare value until a match
    apb(1, TCR_IDX_CMPA_LO, 8'h78);
    apb(1, TCR_IDX_CMPA_HI, 8'h56);
    cyc(2);
    check({16'h0, compare_reg_a}, 32'h0000_ffff);
    match_event <= 1'b1;
    @(posedge pclk);
    match_event <= 1'b0;
    cyc(2);
    check({16'h0, compare_reg_a}, 32'h0000_5678);
    stop_entry <= 1'b1;
    @(posedge pclk);
    stop_entry <= 1'b0;
    cyc(1);
    check({31'h0, run_control}, 32'h0000_0000);
    apb(0, TCR_IDX_CTRL, 8'h00);
    check({24'h0, rd}, 32'h0000_0080);
    apb(1, TCR_IDX_CTRL, 8'h00);
    @(posedge pclk);
    ovf_event <= 1'b1;
    @(posedge pclk);
    ovf_event <= 1'b0;
    @(posedge pclk);
    check({31'h0, timer_irq}, 32'h0000_0000);
    $display("run test done");
    // compare pairing with buffering off and the timer stopped
    apb(1, TCR_IDX_MODE, 8'h00);
    apb(1, TCR_IDX_CMPA_LO, 8'h34);
    cyc(2);
    check({16'h0, compare_reg_a}, 32'h0000_5678);
    apb(1, TCR_IDX_CMPA_HI, 8'h12);
    cyc(2);
    check({16'h0, compare_reg_a}, 32'h0000_1234);
    apb(0, TCR_IDX_CMPA_LO, 8'h00);
    check({24'h0, rd}, 32'h0000_0034);
    apb(0, 14'h0040, 8'h00);
    check({31'h0, err}, 32'h0000_0001);
    // a low clock enable must drop the capture event
    @(posedge pclk);
    ce <= 1'b0;
    cap_a_event <= 1'b1;
    @(posedge pclk);
    ce <= 1'b1;
    cap_a_event <= 1'b0;
    apb(0, TCR_IDX_STAT, 8'h00);
    check({24'h0, rd}, 32'h0000_0080);
    $display("compare and address test done");
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(2);
    check({16'h0, compare_reg_a}, 32'h0000_ffff);
    check({31'h0, clock_gate_ch0}, 32'h0000_0000);
    presetn <= 1'b1;
    cyc(2);
    apb(0, TCR_IDX_MODE, 8'h00);
    check({24'h0, rd}, 32'h0000_0080);
    $display("reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
